/* hdl/vrad_defines.vh */
/*
 * Constants for the voice ROM and audio DAC register block: data-memory
 * offsets, control bit positions, reset values and fetch timing.
 * Assumes it is included by bare name into the design files.
 */
`ifndef VRAD_DEFINES_VH
`define VRAD_DEFINES_VH

// ==========================================================
// Register offsets in data memory
`define VRAD_OFS_SET0_HIGH   8'h18
`define VRAD_OFS_SET0_MID    8'h19
`define VRAD_OFS_SET0_LOW    8'h1a
`define VRAD_OFS_SET1_HIGH   8'h1b
`define VRAD_OFS_SET1_MID    8'h1c
`define VRAD_OFS_SET1_LOW    8'h1d
`define VRAD_OFS_SPEECH_CTRL 8'h26
`define VRAD_OFS_SAMPLE_LOW  8'h27
`define VRAD_OFS_SAMPLE_HIGH 8'h28
`define VRAD_OFS_LOUDNESS    8'h29
`define VRAD_OFS_ROM_BYTE    8'h2a

// ==========================================================
// Control register bit positions
`define VRAD_BIT_DAC_EN      1
`define VRAD_BIT_ROM_EN      2
`define VRAD_BIT_SET_SEL     4
`define VRAD_CTRL_RW_MASK    8'h16

// ==========================================================
// Widths and reset values
`define VRAD_ROM_AW          18
`define VRAD_CTRL_RST        8'h00
`define VRAD_BYTE_RST        8'h00

// ==========================================================
// Fetch latency: at least 4 us at 10 ns per cycle
`define VRAD_FETCH_NS        4000
`define VRAD_CLK_NS          10
// Sized so the 12-bit wait counter takes it without truncation
`define VRAD_FETCH_CYC       12'h190

`endif

/* hdl/vrad_rom_fetch.v */
/*
 * Voice ROM fetch sequencer: restarts on every address change, waits
 * the fetch time, then captures the ROM byte into a holding latch.
 * Assumes a synchronous ROM read port with one cycle of latency.
 */
`include "vrad_defines.vh"

module vrad_rom_fetch (
  // Clock and reset
  input  wire                      i_clk_sys,
  input  wire                      i_rst,
  input  wire                      i_ce,
  // Control
  input  wire                      i_rom_en,
  input  wire                      i_restart,
  // ROM data
  input  wire [7:0]                i_rom_data,
  // Result
  output reg  [7:0]                o_byte,
  output reg                       o_busy
);

  localparam [11:0] FETCH_CYC = `VRAD_FETCH_CYC; // Cycles to wait

  reg [11:0] wait_r;                             // Remaining wait count

  // ==========================================================
  // Wait counter and byte capture
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      wait_r <= 12'h000;
      o_busy <= 1'b0;
      o_byte <= `VRAD_BYTE_RST;
    end else if (i_ce) begin
      if (!i_rom_en) begin
        // Disabled circuit: nothing reaches the latch
        wait_r <= 12'h000;
        o_busy <= 1'b0;
        o_byte <= `VRAD_BYTE_RST;                // see (R8)
      end else if (i_restart) begin
        // New address: start the full wait again
        wait_r <= FETCH_CYC;                     // see (R12)
        o_busy <= 1'b1;
      end else if (wait_r != 12'h000) begin
        wait_r <= wait_r - 12'h001;
        if (wait_r == 12'h001) begin
          // ROM word has settled long ago; take it
          o_byte <= i_rom_data;                  // see (R13)
          o_busy <= 1'b0;
        end
      end
    end
  end

endmodule

/* hdl/vrad_voice_regs.v */
// Functional notes
// (R1) Sample is low upper nibble plus high byte
// (R2) Low sample register reads zero low nibble
// (R3) Eight volume levels from volume upper nibble
// (R4) Volume register reads zero low nibble
// (R5) Disabled DAC gives no valid output
// (R6) Control bit 1 enables the DAC
// (R7) Halt leaves DAC state untouched
// (R8) Control bit 2 enables ROM access
// (R9) Control bit 4 picks address set
// (R10) Control bits 0,3,5,6 read zero
// (R11) Each set forms 18-bit byte address
// (R12) Software waits 4 us before reading
// (R13) Fetched byte readable at 2AH
// (R14) Software enables, selects, loads, waits, reads
// (R15) Software writes both sample registers
// (R16) High byte bits 11:4, nibble bits 3:0
/*
 * Register block for the voice subsystem: sample and volume registers
 * feeding the DAC, speech control, two ROM address sets and the fetched
 * ROM byte. Assumes the core presents a one-cycle write or read strobe
 * with an 8-bit data-memory address; read data is registered.
 */
`include "vrad_defines.vh"

module vrad_voice_regs (
  // Clock, reset and enable
  input  wire                      i_clk_sys,
  input  wire                      i_rst,
  input  wire                      i_ce,
  // Data-memory access from the core
  input  wire [7:0]                i_addr,
  input  wire                      i_wr,
  input  wire                      i_rd,
  input  wire [7:0]                i_wdata,
  output reg  [7:0]                o_rdata,
  // Core power state
  input  wire                      i_halt,
  // Voice ROM port
  output reg  [17:0]               o_rom_addr,
  output reg                       o_rom_en,
  input  wire [7:0]                i_rom_data,
  // DAC port
  output reg  [11:0]               o_dac_code,
  output reg  [2:0]                o_dac_vol,
  output reg                       o_dac_en,
  output reg                       o_dac_valid,
  // Status
  output reg                       o_fetch_busy
);

  // ==========================================================
  // Storage
  reg  [7:0]  ctrl_r;                  // Speech control, only rw bits
  reg  [3:0]  samp_lo_r;               // Upper nibble of low sample
  reg  [7:0]  samp_hi_r;               // High sample byte
  reg  [3:0]  vol_r;                   // Volume upper nibble
  reg  [17:0] set_addr_r [0:1];        // Two address latch sets
  reg         restart_r;               // Address just changed
  wire [7:0]  rom_byte;                // Latched ROM byte
  wire        busy;                    // Fetch in progress
  reg  [7:0]  rdata_nxt;               // Read mux result
  wire        sel_set;                 // Active address set

  assign sel_set = ctrl_r[`VRAD_BIT_SET_SEL];              // see (R9)

  // Decode a set-0 address to a field: 6=high 5=mid 4=low; set-1 offsets decode to 7 or 0
  function [2:0] set_field;
    input [7:0] a;
    begin
      case (a)
        `VRAD_OFS_SET0_HIGH: set_field = 3'b110;
        `VRAD_OFS_SET0_MID:  set_field = 3'b101;
        `VRAD_OFS_SET0_LOW:  set_field = 3'b100;
        `VRAD_OFS_SET1_HIGH: set_field = 3'b111;
        `VRAD_OFS_SET1_MID:  set_field = 3'b111;
        default:             set_field = 3'b000;
      endcase
    end
  endfunction

  // Set index for an address-set offset
  function set_idx;
    input [7:0] a;
    begin
      set_idx = (a >= `VRAD_OFS_SET1_HIGH);
    end
  endfunction

  // ==========================================================
  // Register writes; halt is deliberately ignored here
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_r    <= `VRAD_CTRL_RST;
      samp_lo_r <= 4'h0;
      samp_hi_r <= 8'h00;
      vol_r     <= 4'h0;
      restart_r <= 1'b0;
      set_addr_r[0] <= 18'h00000;
      set_addr_r[1] <= 18'h00000;
    end else if (i_ce) begin
      restart_r <= 1'b0;
      if (i_wr) begin
        case (i_addr)
          `VRAD_OFS_SPEECH_CTRL: begin
            // Unused bits never stored, so read as zero
            ctrl_r <= i_wdata & `VRAD_CTRL_RW_MASK;         // see (R6) (R10)
          end
          `VRAD_OFS_SAMPLE_LOW: begin
            samp_lo_r <= i_wdata[7:4];                      // see (R1)
          end
          `VRAD_OFS_SAMPLE_HIGH: begin
            samp_hi_r <= i_wdata;                           // see (R1)
          end
          `VRAD_OFS_LOUDNESS: begin
            vol_r <= i_wdata[7:4];                          // see (R3)
          end
          `VRAD_OFS_SET0_HIGH, `VRAD_OFS_SET1_HIGH: begin
            set_addr_r[set_idx(i_addr)][17:16] <= i_wdata[1:0]; // see (R11)
            restart_r <= 1'b1;
          end
          `VRAD_OFS_SET0_MID, `VRAD_OFS_SET1_MID: begin
            set_addr_r[set_idx(i_addr)][15:8] <= i_wdata;   // see (R11)
            restart_r <= 1'b1;
          end
          `VRAD_OFS_SET0_LOW, `VRAD_OFS_SET1_LOW: begin
            set_addr_r[set_idx(i_addr)][7:0] <= i_wdata;    // see (R11)
            restart_r <= 1'b1;
          end
          default: begin
            // Unmapped offsets belong to other blocks
          end
        endcase
      end else if (i_wr == 1'b0 && ctrl_r[`VRAD_BIT_SET_SEL] != sel_set) begin
        restart_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux; narrow fields pad with zeros
  always @* begin
    case (i_addr)
      `VRAD_OFS_SPEECH_CTRL: rdata_nxt = ctrl_r;            // see (R10)
      `VRAD_OFS_SAMPLE_LOW:  rdata_nxt = {samp_lo_r, 4'h0}; // see (R2)
      `VRAD_OFS_SAMPLE_HIGH: rdata_nxt = samp_hi_r;
      `VRAD_OFS_LOUDNESS:    rdata_nxt = {vol_r, 4'h0};     // see (R4)
      `VRAD_OFS_ROM_BYTE:    rdata_nxt = rom_byte;          // see (R13)
      `VRAD_OFS_SET0_HIGH:   rdata_nxt = {6'h00, set_addr_r[0][17:16]};
      `VRAD_OFS_SET0_MID:    rdata_nxt = set_addr_r[0][15:8];
      `VRAD_OFS_SET0_LOW:    rdata_nxt = set_addr_r[0][7:0];
      `VRAD_OFS_SET1_HIGH:   rdata_nxt = {6'h00, set_addr_r[1][17:16]};
      `VRAD_OFS_SET1_MID:    rdata_nxt = set_addr_r[1][15:8];
      `VRAD_OFS_SET1_LOW:    rdata_nxt = set_addr_r[1][7:0];
      default:               rdata_nxt = 8'h00;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata      <= 8'h00;
      o_rom_addr   <= 18'h00000;
      o_rom_en     <= 1'b0;
      o_dac_code   <= 12'h000;
      o_dac_vol    <= 3'h0;
      o_dac_en     <= 1'b0;
      o_dac_valid  <= 1'b0;
      o_fetch_busy <= 1'b0;
    end else if (i_ce) begin
      o_rdata      <= i_rd ? rdata_nxt : 8'h00;
      o_rom_addr   <= set_addr_r[sel_set];                  // see (R9) (R11)
      o_rom_en     <= ctrl_r[`VRAD_BIT_ROM_EN];             // see (R8)
      // Halt input not used: the enable bit alone governs
      o_dac_en     <= ctrl_r[`VRAD_BIT_DAC_EN];             // see (R6) (R7)
      // Code zeroed while disabled so stale samples never sound
      o_dac_code   <= ctrl_r[`VRAD_BIT_DAC_EN] ?
                      {samp_hi_r, samp_lo_r} : 12'h000;     // see (R16) (R5)
      o_dac_valid  <= ctrl_r[`VRAD_BIT_DAC_EN];             // see (R5)
      // Eight levels: top three bits of the nibble
      o_dac_vol    <= vol_r[3:1];                           // see (R3)
      o_fetch_busy <= busy;
    end
  end

  // ==========================================================
  // Fetch sequencer; a set-select change also restarts the wait
  reg sel_q_r;                         // Previous set select
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel_q_r <= 1'b0;
    end else if (i_ce) begin
      sel_q_r <= sel_set;
    end
  end

  vrad_rom_fetch u_fetch (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_rom_en   (ctrl_r[`VRAD_BIT_ROM_EN]),                 // see (R8)
    .i_restart  (restart_r | (sel_q_r != sel_set)),
    .i_rom_data (i_rom_data),
    .o_byte     (rom_byte),
    .o_busy     (busy)
  );

endmodule

/* verif/vrad_voice_regs_props.sv */
/* Checker for the voice register block.
   Assumes it is bound to vrad_voice_regs, i_ce held high. */
module vrad_voice_regs_props (
  // Clock, reset and core access
  input logic        i_clk_sys, i_rst, i_ce, i_wr, i_rd,
  input logic [7:0]  i_addr, i_wdata, o_rdata,
  // Status and DAC side
  input logic        o_rom_en, o_dac_en, o_dac_valid, o_fetch_busy,
  input logic [11:0] o_dac_code,
  input logic [2:0]  o_dac_vol
);
  // ==========================================
  // Write decodes
  wire w26 = i_ce && i_wr && i_addr == 8'h26;
  wire w28 = i_ce && i_wr && i_addr == 8'h28;
  wire w29 = i_ce && i_wr && i_addr == 8'h29;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Properties
  a_valid_follows: assert property (o_dac_valid == o_dac_en)
    else $error("dac valid differs from enable");
  a_off_silent: assert property (!o_dac_en |-> o_dac_code == 12'h000)
    else $error("dac code while disabled");
  a_dac_bit: assert property (w26 |-> ##2 o_dac_en == $past(i_wdata[1], 2))
    else $error("dac enable bit");
  a_rom_bit: assert property (w26 |-> ##2 o_rom_en == $past(i_wdata[2], 2))
    else $error("rom enable bit");
  a_vol_level: assert property (w29 |-> ##2 o_dac_vol == $past(i_wdata[7:5], 2))
    else $error("volume level");
  a_code_high: assert property (w28 && o_dac_en |->
    ##2 o_dac_code[11:4] == $past(i_wdata, 2))
    else $error("sample high byte");
  a_read_pulse: assert property (o_rdata != 8'h00 |-> $past(i_rd))
    else $error("read data without read");
  a_rom_off_zero: assert property (i_rd && i_addr == 8'h2a && !o_rom_en
    |=> o_rdata == 8'h00)
    else $error("rom byte while disabled");
  // Restarts by later address writes may stretch the wait a little
  a_fetch_time: assert property ($rose(o_fetch_busy)
    |-> ##[395:440] !o_fetch_busy)
    else $error("fetch wait length");
endmodule

bind vrad_voice_regs vrad_voice_regs_props u_vrad_voice_regs_props (
  .i_clk_sys, .i_rst, .i_ce, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
  .o_rom_en, .o_dac_en, .o_dac_valid, .o_fetch_busy, .o_dac_code,
  .o_dac_vol);

/* verif/vrad_voice_regs_tb.sv */
/* Self-checking bench for the voice register block.
   Assumes a one-cycle synchronous voice ROM, modelled here. */
module vrad_voice_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Stimulus and observed signals
  logic i_clk_sys = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0, i_halt = 0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, i_rom_data = 8'h00, o_rdata;
  logic [17:0] o_rom_addr;
  logic [11:0] o_dac_code;
  logic [2:0]  o_dac_vol;
  logic        o_rom_en, o_dac_en, o_dac_valid, o_fetch_busy, rd_d = 0;
  logic [7:0]  exp_q[$];  // Expected read data, oldest first
  logic [7:0]  a, b, h, m, l;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  vrad_voice_regs u_vrad_voice_regs (.i_clk_sys, .i_rst, .i_ce, .i_addr,
    .i_wr, .i_rd, .i_wdata, .o_rdata, .i_halt, .o_rom_addr, .o_rom_en,
    .i_rom_data, .o_dac_code, .o_dac_vol, .o_dac_en, .o_dac_valid,
    .o_fetch_busy);
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // ==========================================
  // Voice ROM model: contents derived from the address
  function automatic logic [7:0] rom_f(logic [17:0] x);
    return x[7:0] ^ x[15:8] ^ {6'h00, x[17:16]} ^ 8'h3c;
  endfunction
  always @(posedge i_clk_sys) i_rom_data <= rom_f(o_rom_addr);
  // ==========================================
  // Read monitor; also cuts a hang short
  always @(posedge i_clk_sys) begin
    if (rd_d) begin
      n_tests++;
      if (exp_q.size() == 0 || o_rdata !== exp_q[0]) begin
        bad_count++;
        $display("MISMATCH %0t read data %h", $time, o_rdata);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    rd_d <= i_rd & ~i_rst;
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end
  // ==========================================
  // Access tasks, entered just after a falling edge
  task automatic chk(logic [17:0] got, logic [17:0] e);
    n_tests++;
    if (got !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    i_addr = ad;
    i_wdata = d;
    i_wr = 1;
    @(negedge i_clk_sys) i_wr = 0;
    @(negedge i_clk_sys);
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    exp_q.push_back(e);
    i_addr = ad;
    i_rd = 1;
    @(negedge i_clk_sys) i_rd = 0;
    @(negedge i_clk_sys);
  endtask
  task automatic results();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(11171));
    repeat (6) @(negedge i_clk_sys);
    i_rst = 0;
    // Control bits; ROM kept off so no fetch starts here
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'hea : 8'($urandom) & 8'hea;
      i_halt = a[3];
      wr(8'h26, a);
      chk(o_dac_en, a[1]);
      chk(o_dac_valid, a[1]);
      rd(8'h26, a & 8'h16);
    end
    // Sample word with halt raised
    wr(8'h26, 8'h02);
    a = 8'($urandom);
    b = 8'($urandom);
    wr(8'h27, a);
    wr(8'h28, b);
    i_halt = 1;
    chk(o_dac_code, {b, a[7:4]});
    rd(8'h27, a & 8'hf0);
    rd(8'h28, b);
    chk(o_dac_en, 1'b1);
    wr(8'h26, 8'h00);
    chk(o_dac_code, 12'h000);
    i_halt = 0;
    // All eight volume levels
    for (int v = 0; v < 8; v++) begin
      a = {3'(v), 5'($urandom)};
      wr(8'h29, a);
      chk(o_dac_vol, v[2:0]);
      rd(8'h29, a & 8'hf0);
    end
    // ROM fetch through each address set
    for (int s = 0; s < 2; s++) begin
      h = 8'($urandom);
      m = 8'($urandom);
      l = 8'($urandom);
      wr(8'h26, {3'h0, 1'(s), 4'h4});
      wr(8'h1a + 8'(3 * s), l);
      wr(8'h19 + 8'(3 * s), m);
      wr(8'h18 + 8'(3 * s), h);
      for (int n = 0; n < 500 && (o_fetch_busy !== 1'b0 || n < 3); n++)
        @(negedge i_clk_sys);
      chk(o_rom_addr, {h[1:0], m, l});
      rd(8'h2a, rom_f({h[1:0], m, l}));
      rd(8'h18 + 8'(3 * s), h & 8'h03);
      rd(8'h26, {3'h0, 1'(s), 4'h4});
    end
    // Disabled ROM and an unmapped place
    wr(8'h26, 8'h00);
    rd(8'h2a, 8'h00);
    rd(8'h30, 8'h00);
    results();
  end
endmodule
